/* ars_top.sv */
/*
 * Auto-reclose sequencer with AXI4-Lite register slave and a masked
 * interrupt. Assumes trip and breaker-open pins are asynchronous levels
 * and that a close command is dropped by the breaker reporting closed.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module ars_top
	import ars_pkg::*;
(
	// clock, reset, enable
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              clk_en,
	// protection and breaker pins
	input  wire logic              trip_phase,
	input  wire logic              trip_ground,
	input  wire logic              brk_open,
	output logic                   close_cmd,
	output logic                   irq,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	typedef struct packed {
		ars_state_e                             st;
		logic                                   prog;
		logic [CNT_W-1:0]                       att;
		logic [TMR_W-1:0]                       tmr;
		logic [TMR_W-1:0]                       presc;
		logic                                   tick;
		logic [2:0]                             ph_s;
		logic [2:0]                             gd_s;
		logic [2:0]                             op_s;
		logic                                   ph_f;
		logic                                   gd_f;
		logic                                   op_f;
		logic [2:0]                             ctrl;
		logic [TMR_W-1:0]                       presc_set;
		logic [1:0][CNT_W-1:0]                  shots;
		logic [1:0][DEAD_SLOTS-1:0][TMR_W-1:0]  dead;
		logic [TMR_W-1:0]                       blk;
		logic [EV_N-1:0]                        istat;
		logic [EV_N-1:0]                        imask;
		logic                                   irq;
		logic                                   close;
		logic                                   aw_rdy;
		logic                                   w_rdy;
		logic [ADDR_W-1:0]                      awa;
		logic [31:0]                            wd;
		logic [3:0]                             ws;
		logic                                   bv;
		logic [1:0]                             br;
		logic                                   ar_rdy;
		logic                                   rv;
		logic [31:0]                            rd;
		logic [1:0]                             rr;
	} ars_state_s;

	ars_state_s s_reg;
	ars_state_s s_next;

	// byte-lane merge of a write into an old register value
	function automatic logic [31:0] ars_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : ars_merge

	// settings above nine are held at nine
	function automatic logic [CNT_W-1:0] ars_clamp(input logic [CNT_W-1:0] v);
		return (v > MAX_SHOTS) ? MAX_SHOTS : v; // RQ10
	endfunction : ars_clamp

	// register read mux; unmapped addresses read zero with an error
	function automatic logic [32:0] ars_read(input ars_state_s s, input logic [ADDR_W-1:0] a);
		logic [31:0] d;
		logic        hit;
		d = 32'h0000_0000;
		hit = 1'b1;
		unique case (a)
			OFF_CTRL:   d[2:0] = s.ctrl;
			OFF_PRESC:  d[TMR_W-1:0] = s.presc_set;
			OFF_SHOTS:  begin
				d[CNT_W-1:0] = s.shots[PROG_PH];
				d[SHOTS_GD_POS +: CNT_W] = s.shots[PROG_GD];
			end
			OFF_BLOCK:  d[TMR_W-1:0] = s.blk;
			OFF_STATUS: begin
				d[2:0] = s.st;
				d[ST_ATT_POS +: CNT_W] = s.att;
				d[ST_PROG_POS] = s.prog;
				d[ST_CLOSE_POS] = s.close;
				d[ST_OPEN_POS] = s.op_f;
			end
			OFF_ISTAT:  d[EV_N-1:0] = s.istat;
			OFF_IMASK:  d[EV_N-1:0] = s.imask;
			default:    hit = 1'b0;
		endcase
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < DEAD_SLOTS; k++) begin
				if (a == OFF_DEAD + ADDR_W'(p) * PROG_STEP + ADDR_W'(k * 4)) begin
					d[TMR_W-1:0] = s.dead[p][k];
					hit = 1'b1;
				end
			end
		end
		return {hit, d};
	endfunction : ars_read

	logic [32:0] rd_mux;
	logic [32:0] wr_mux;
	logic        wr_go;
	logic [31:0] wr_d;
	logic [31:0] old_v;
	logic        wr_hit;
	logic        srst;
	logic        unblk;
	logic        ph_rise;
	logic        gd_rise;
	logic        ph_start;
	logic        gd_start;
	logic        tmr_done;
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] clr;
	logic [1:0]  dsel;

	always_comb begin
		s_next = s_reg;
		rd_mux = ars_read(s_reg, s_axi_araddr);
		wr_mux = ars_read(s_reg, s_reg.awa);
		old_v = wr_mux[31:0];
		wr_hit = wr_mux[32];
		wr_go = !s_reg.aw_rdy && !s_reg.w_rdy && !s_reg.bv;
		wr_d = ars_merge(old_v, s_reg.wd, s_reg.ws);
		srst = 1'b0;
		unblk = 1'b0;
		clr = '0;
		ev = '0;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_reg.aw_rdy) begin
			s_next.aw_rdy = 1'b0;
			s_next.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.w_rdy) begin
			s_next.w_rdy = 1'b0;
			s_next.wd = s_axi_wdata;
			s_next.ws = s_axi_wstrb;
		end
		if (wr_go) begin
			s_next.bv = 1'b1;
			s_next.br = wr_hit ? RESP_OK : RESP_ERR;
			unique case (s_reg.awa)
				OFF_CTRL: begin
					s_next.ctrl = wr_d[2:0];
					srst = wr_d[CTRL_SRST] && s_reg.ws[0];
					unblk = wr_d[CTRL_UNBLK] && s_reg.ws[0];
				end
				OFF_PRESC: s_next.presc_set = wr_d[TMR_W-1:0];
				OFF_SHOTS: begin
					s_next.shots[PROG_PH] = ars_clamp(wr_d[CNT_W-1:0]); // RQ11
					s_next.shots[PROG_GD] = ars_clamp(wr_d[SHOTS_GD_POS +: CNT_W]); // RQ11
				end
				OFF_BLOCK: s_next.blk = wr_d[TMR_W-1:0];
				OFF_ISTAT: clr = s_reg.wd[EV_N-1:0] & {EV_N{s_reg.ws[0]}};
				OFF_IMASK: s_next.imask = wr_d[EV_N-1:0];
				default: ;
			endcase
			for (int p = 0; p < 2; p++) begin
				for (int k = 0; k < DEAD_SLOTS; k++) begin
					if (s_reg.awa == OFF_DEAD + ADDR_W'(p) * PROG_STEP + ADDR_W'(k * 4)) begin
						s_next.dead[p][k] = wr_d[TMR_W-1:0]; // RQ5 RQ14
					end
				end
			end
		end
		if (s_reg.bv && s_axi_bready) begin
			s_next.bv = 1'b0;
			s_next.aw_rdy = 1'b1;
			s_next.w_rdy = 1'b1;
		end

		// read channel: one-cycle answer after the address is taken
		if (s_axi_arvalid && s_reg.ar_rdy) begin
			s_next.ar_rdy = 1'b0;
			s_next.rv = 1'b1;
			s_next.rd = rd_mux[31:0];
			s_next.rr = rd_mux[32] ? RESP_OK : RESP_ERR;
		end
		if (s_reg.rv && s_axi_rready) begin
			s_next.rv = 1'b0;
			s_next.ar_rdy = 1'b1;
		end

		// pin synchronisers; a level counts once stages two and three agree
		s_next.ph_s = {s_reg.ph_s[1:0], trip_phase};
		s_next.gd_s = {s_reg.gd_s[1:0], trip_ground};
		s_next.op_s = {s_reg.op_s[1:0], brk_open};
		if (s_reg.ph_s[1] == s_reg.ph_s[2]) begin
			s_next.ph_f = s_reg.ph_s[2];
		end
		if (s_reg.gd_s[1] == s_reg.gd_s[2]) begin
			s_next.gd_f = s_reg.gd_s[2];
		end
		if (s_reg.op_s[1] == s_reg.op_s[2]) begin
			s_next.op_f = s_reg.op_s[2];
		end
		ph_rise = s_next.ph_f && !s_reg.ph_f;
		gd_rise = s_next.gd_f && !s_reg.gd_f;
		ph_start = s_reg.ph_f && s_reg.ctrl[CTRL_PH_EN] && (s_reg.shots[PROG_PH] != '0);
		gd_start = s_reg.gd_f && s_reg.ctrl[CTRL_GD_EN] && (s_reg.shots[PROG_GD] != '0);

		// prescaler tick drives both timers
		s_next.tick = 1'b0;
		if (s_reg.presc == '0) begin
			s_next.presc = s_reg.presc_set; // RQ19
			s_next.tick = 1'b1; // RQ19
		end else begin
			s_next.presc = s_reg.presc - 1'b1;
		end
		tmr_done = s_reg.tick && (s_reg.tmr <= TMR_W'(1));
		if (s_reg.tick && !tmr_done) begin
			s_next.tmr = s_reg.tmr - 1'b1; // RQ19
		end
		// attempts past the fourth reuse the fourth dead time
		dsel = (s_reg.att >= CNT_W'(DEAD_SLOTS - 1)) ? 2'(DEAD_SLOTS - 1) : s_reg.att[1:0]; // RQ15

		unique case (s_reg.st)
			ST_IDLE: begin
				s_next.att = '0; // RQ18
				s_next.close = 1'b0;
				if (ph_start || gd_start) begin
					s_next.prog = ph_start ? PROG_PH : PROG_GD; // RQ1
					s_next.st = ST_WAIT_OPEN; // RQ1
				end
			end
			ST_WAIT_OPEN: begin
				if (s_reg.op_f) begin
					s_next.tmr = s_reg.dead[s_reg.prog][dsel]; // RQ2 RQ5 RQ14
					s_next.st = ST_DEAD; // RQ2
				end
			end
			ST_DEAD: begin
				if (tmr_done) begin
					s_next.close = 1'b1; // RQ3 RQ13
					s_next.tmr = s_reg.blk; // RQ4
					s_next.att = s_reg.att + 1'b1; // RQ18
					s_next.st = ST_BLOCK; // RQ4
					ev[EV_CLOSE] = 1'b1;
				end
			end
			ST_BLOCK: begin
				// the breaker reporting closed ends the close command
				if (!s_reg.op_f) begin
					s_next.close = 1'b0;
				end
				if (ph_rise || gd_rise) begin
					s_next.close = 1'b0;
					if (s_reg.att < s_reg.shots[s_reg.prog]) begin
						s_next.st = ST_WAIT_OPEN; // RQ12
						s_next.tmr = '0; // RQ12
					end else begin
						s_next.st = ST_LOCK; // RQ7 RQ8 RQ9 RQ17
						ev[EV_LOCK] = 1'b1;
					end
				end else if (tmr_done) begin
					s_next.close = 1'b0;
					s_next.st = ST_IDLE; // RQ6 RQ16
					s_next.att = '0; // RQ18
					ev[EV_OK] = 1'b1;
				end
			end
			ST_LOCK: begin
				// no close leaves this state; only software releases it
				s_next.close = 1'b0; // RQ8 RQ17
				if (unblk) begin
					s_next.st = ST_IDLE; // RQ9
				end
			end
		endcase

		// disabling or soft reset abandons any sequence in progress
		if (!s_reg.ctrl[CTRL_EN] || srst) begin
			s_next.st = ST_IDLE; // RQ19
			s_next.tmr = '0; // RQ19
			s_next.presc = '0;
			s_next.att = '0;
			s_next.close = 1'b0;
		end

		// a new event wins over a clear in the same cycle
		s_next.istat = (s_reg.istat & ~clr) | ev;
		s_next.irq = |(s_next.istat & s_next.imask);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.ctrl <= CTRL_RST;
			s_reg.presc_set <= PRESC_RST;
			s_reg.shots <= {SHOTS_RST, SHOTS_RST};
			s_reg.dead <= {(2 * DEAD_SLOTS){DEAD_RST}};
			s_reg.blk <= BLOCK_RST;
			s_reg.aw_rdy <= 1'b1;
			s_reg.w_rdy <= 1'b1;
			s_reg.ar_rdy <= 1'b1;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign close_cmd = s_reg.close;
	assign irq = s_reg.irq;
	assign s_axi_awready = s_reg.aw_rdy;
	assign s_axi_wready = s_reg.w_rdy;
	assign s_axi_bvalid = s_reg.bv;
	assign s_axi_bresp = s_reg.br;
	assign s_axi_arready = s_reg.ar_rdy;
	assign s_axi_rvalid = s_reg.rv;
	assign s_axi_rdata = s_reg.rd;
	assign s_axi_rresp = s_reg.rr;

endmodule : ars_top

/* ars_pkg.sv */
/*
 * Constants, register map and state types of the auto-reclose sequencer.
 * Assumes a 40 MHz sys_clk and an AXI4-Lite master with 32-bit data.
 */
// How it works
// [RQ1] an enabled phase or ground trip starts its own reclose program
// [RQ2] dead timer starts only after the breaker reports open
// [RQ3] dead timer expiry raises the breaker close command
// [RQ4] blocking timer starts in the same cycle as the close command
// [RQ5] each program has its own dead-time settings
// [RQ6] blocking expiry without new fault means success, back to idle
// [RQ7] failed single shot leaves the protection's final trip standing, no reclose
// [RQ8] new fault during blocking with no attempts left gives no close
// [RQ9] failed final attempt enters a blocked state that inhibits reclosing
// [RQ10] attempt count per sequence is settable, at most nine
// [RQ11] each program has its own attempt count setting
// [RQ12] multi-shot failure in blocking resets blocking timer, starts next dead time
// [RQ13] each later dead time ends in the next close until count used
// [RQ14] first four attempts have individual dead times per program
// [RQ15] attempts five to nine reuse the fourth dead time
// [RQ16] any blocking expiry without fault returns the function to idle
// [RQ17] after every attempt failed, final trip stands and no close follows
// [RQ18] attempt counter clears at idle, counts each close of a sequence
// [RQ19] timers run on a prescaler tick; soft reset clears all to idle
package ars_pkg;
	localparam int ADDR_W = 8;
	localparam int TMR_W  = 16;
	localparam int CNT_W  = 4;
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_US = 1000;
	localparam logic [TMR_W-1:0] PRESC_RST = TMR_W'(CLK_HZ / 1_000_000 * TICK_US - 1);
	localparam logic [CNT_W-1:0] MAX_SHOTS = 4'h9;
	localparam logic [CNT_W-1:0] SHOTS_RST = 4'h1;
	localparam int DEAD_SLOTS = 4;
	localparam logic [TMR_W-1:0] DEAD_RST  = 16'h01f4;
	localparam logic [TMR_W-1:0] BLOCK_RST = 16'h0bb8;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PRESC  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SHOTS  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_BLOCK  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_DEAD   = 8'h10;
	localparam logic [ADDR_W-1:0] PROG_STEP  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_ISTAT  = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_IMASK  = 8'h38;
	localparam int CTRL_EN = 0;
	localparam int CTRL_PH_EN = 1;
	localparam int CTRL_GD_EN = 2;
	localparam int CTRL_SRST = 3;
	localparam int CTRL_UNBLK = 4;
	localparam logic [2:0] CTRL_RST = 3'h7;
	localparam int SHOTS_GD_POS = 8;
	localparam int EV_CLOSE = 0;
	localparam int EV_OK = 1;
	localparam int EV_LOCK = 2;
	localparam int EV_N = 3;
	localparam int ST_ATT_POS = 4;
	localparam int ST_PROG_POS = 8;
	localparam int ST_CLOSE_POS = 9;
	localparam int ST_OPEN_POS = 10;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic PROG_PH = 1'b0;
	localparam logic PROG_GD = 1'b1;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT_OPEN, ST_DEAD, ST_BLOCK, ST_LOCK} ars_state_e;
endpackage : ars_pkg

/* ars_asserts.sv */
/*
 * Concurrent checks on the pins and the AXI4-Lite port of the sequencer.
 * Assumes binding to ars_top and a breaker that stays open while closing.
 */
`timescale 1ns/1ps
module ars_asserts
	import ars_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// breaker pins
	input wire logic        brk_open,
	input wire logic        close_cmd,
	input wire logic        irq,
	// axi4-lite
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_RESET: assert property ($rose(rst_b) |-> !close_cmd && !irq && !s_axi_bvalid)
		else $error("outputs not idle after reset");
	// the pin filter needs several cycles, so the raw open level precedes any close
	AST_CLOSE_OPEN: assert property ($rose(close_cmd) |-> $past(brk_open, 3))
		else $error("close without open breaker");
	AST_AW: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high");
	AST_W: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("wready stayed high");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write response not retired");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule : ars_asserts

bind ars_top ars_asserts ars_asserts_i (.sys_clk(sys_clk), .rst_b(rst_b), .brk_open(brk_open),
	.close_cmd(close_cmd), .irq(irq), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata));

/* ars_breaker.sv */
/*
 * Breaker and protection model: trips while a fault flows through a closed
 * breaker, moves OP_T cycles after a trip or a close request.
 * Assumes the bench commands faults and manual closes.
 */
`timescale 1ns/1ps
module ars_breaker #(
	parameter int OP_T = 6
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// bench commands
	input  wire logic fault_ph,
	input  wire logic fault_gd,
	input  wire logic man_close,
	// device pins
	input  wire logic close_cmd,
	output logic      trip_phase,
	output logic      trip_ground,
	output logic      brk_open
);
	int  cnt;
	logic pend;
	// an open breaker carries no fault current, so the trip falls away
	assign trip_phase  = fault_ph & ~brk_open;
	assign trip_ground = fault_gd & ~brk_open;
	assign pend        = brk_open ? (close_cmd | man_close) : (trip_phase | trip_ground);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			brk_open <= 1'b0;
			cnt      <= 0;
		end else if (pend && cnt == OP_T - 1) begin
			brk_open <= ~brk_open;
			cnt      <= 0;
		end else begin
			cnt <= pend ? cnt + 1 : 0;
		end
	end
endmodule : ars_breaker

/* ars_top_test.sv */
/*
 * Self-checking bench: AXI4-Lite tasks drive reclose sequences against the
 * breaker model. Assumes PRESC=0 gives one tick per cycle.
 */
`timescale 1ns/1ps
module ars_top_test
	import ars_pkg::*;
;
	logic              sys_clk = 0, rst_b = 0, fault_ph = 0, fault_gd = 0, man_close = 0;
	logic              trip_phase, trip_ground, brk_open, close_cmd, irq, cl_q = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [31:0]       wdata = '0, rdata, rd_d;
	logic [1:0]        bresp, rresp, rsp;
	int                miscompares = 0, num_checks = 0, ncl = 0, ocyc = 0;
	int                dq[$];
	int                gexp[5] = '{20, 40, 60, 80, 80};

	ars_top ars_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .trip_phase(trip_phase),
		.trip_ground(trip_ground), .brk_open(brk_open), .close_cmd(close_cmd), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ars_breaker ars_breaker_i (.sys_clk(sys_clk), .rst_b(rst_b), .fault_ph(fault_ph),
		.fault_gd(fault_gd), .man_close(man_close), .close_cmd(close_cmd),
		.trip_phase(trip_phase), .trip_ground(trip_ground), .brk_open(brk_open));

	initial forever #12.5 sys_clk = ~sys_clk;

	// open time before each close, for the dead-time checks
	always @(posedge sys_clk) begin
		ocyc <= brk_open ? ocyc + 1 : 0;
		cl_q <= close_cmd;
		if (close_cmd && !cl_q) begin
			ncl <= ncl + 1;
			dq.push_back(ocyc);
		end
	end

	task automatic conclude();
		$display("checks %0d, miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// handshakes are judged on settled values half a period before the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		@(posedge sys_clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge sys_clk);
			aw_t = awvalid && awready;
			w_t  = wvalid && wready;
			b_t  = bvalid;
			rsp  = bresp;
			@(posedge sys_clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (!b_t);
		bready <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic ar_t, r_t;
		@(posedge sys_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge sys_clk);
			ar_t = arvalid && arready;
			r_t  = rvalid;
			rd_d = rdata;
			rsp  = rresp;
			@(posedge sys_clk);
			if (ar_t) arvalid <= 1'b0;
		end while (!r_t);
		rready <= 1'b0;
		chk(rd_d & m, e);
	endtask : rchk

	task automatic reclose_ready();
		fault_ph <= 1'b0;
		fault_gd <= 1'b0;
		wr(OFF_CTRL, 32'h17);
		man_close <= 1'b1;
		repeat (12) @(posedge sys_clk);
		man_close <= 1'b0;
		rchk(OFF_STATUS, 32'h0, 32'h7);
	endtask : reclose_ready

	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		rchk(OFF_CTRL, 32'h7, '1);
		rchk(OFF_PRESC, 32'h9c3f, '1);
		rchk(OFF_SHOTS, 32'h101, '1);
		rchk(OFF_DEAD + PROG_STEP + 8'h0c, 32'h1f4, '1);
		rchk(8'h40, 32'h0, '1);
		chk(32'(rsp), 32'(RESP_ERR));
		wr(8'h40, 32'h1);
		chk(32'(rsp), 32'(RESP_ERR));
		wr(OFF_SHOTS, 32'h0f0f);
		rchk(OFF_SHOTS, 32'h0909, '1);
		wr(OFF_PRESC, 32'h0);
		// the running prescaler only reloads at zero, so restart it at once
		wr(OFF_CTRL, 32'hf);
		wr(OFF_BLOCK, 32'd40);
		wr(OFF_DEAD, 32'd30);
		for (int i = 0; i < 4; i++)
			wr(OFF_DEAD + PROG_STEP + 8'(4 * i), 32'(gexp[i]));
		wr(OFF_SHOTS, 32'h0501);
		wr(OFF_IMASK, 32'h2);
		// transient phase fault: one close, then success
		fault_ph <= 1'b1;
		for (int n = 0; n < 100 && brk_open !== 1'b1; n++) @(posedge sys_clk);
		fault_ph <= 1'b0;
		repeat (150) @(posedge sys_clk);
		chk(ncl, 1);
		chk(32'(dq[0] >= 30 && dq[0] <= 40), 1);
		rchk(OFF_STATUS, 32'h0, 32'h107);
		rchk(OFF_ISTAT, 32'h3, '1);
		chk(irq, 1'b1);
		wr(OFF_ISTAT, 32'h3);
		repeat (3) @(posedge sys_clk);
		chk(irq, 1'b0);
		// lasting ground fault: five closes then lockout
		fault_gd <= 1'b1;
		repeat (700) @(posedge sys_clk);
		chk(ncl, 6);
		rchk(OFF_STATUS, 32'h154, 32'h1f7);
		rchk(OFF_ISTAT, 32'h4, 32'h4);
		for (int i = 0; i < 5; i++)
			chk(32'(dq[i+1] >= gexp[i] && dq[i+1] <= gexp[i] + 10), 1);
		reclose_ready();
		// lasting phase fault with one shot
		fault_ph <= 1'b1;
		repeat (300) @(posedge sys_clk);
		chk(ncl, 7);
		rchk(OFF_STATUS, 32'h4, 32'h107);
		fault_ph <= 1'b0;
		wr(OFF_CTRL, 32'hf);
		rchk(OFF_STATUS, 32'h0, 32'hf7);
		conclude();
	end
endmodule : ars_top_test
